// *** rle_endpoint.sv ***
// rle_endpoint.sv: remote link endpoint, serial and switch modes, with a
// 1200 baud radio bit line on each side and an apb register slave.
// assumes all inputs synchronous to mclk and a radio that carries the
// frame line transparently.
`timescale 1ns/1ps
`include "rle_map.svh"

// Behaviour
// - mode pin low switch, high serial
// - mode change applied within one second
// - host bytes 9600 baud 8N1 received
// - pacing low when ready, high when busy
// - hold byte, forward at 1200 baud
// - serial pins active only in serial mode
// - switch and station pins only switch mode
// - radio bytes leave serial out 9600 8N1
// - high switch input sends a zero
// - outputs follow input, drop 500 ms later
// - outputs high only on station match
// - open station pins mean address zero
// - resend status byte while any input high
// - status byte inverts switches and station
// - status byte bit 0 always zero
// - switch sender silent with inputs low
// - match inverted station, drive inverted outputs
// - mismatch leaves outputs unchanged
// - bit 0 ignored by switch receiver
module rle_endpoint
  import rle_pkg::*;
#(
  parameter int HOST_BIT_CYC = `RLE_HOST_BIT_CYC, // 9600 bit time
  parameter int LINK_BIT_CYC = `RLE_LINK_BIT_CYC, // 1200 bit time
  parameter int HOLD_CYC = `RLE_HOLD_CYC          // output hold
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode_sel,
  input wire logic ser_in,
  output logic pace_busy_out,
  output logic ser_out,
  input wire logic switch_input_a,
  input wire logic switch_input_b,
  input wire logic switch_input_c,
  output logic switch_output_a,
  output logic switch_output_b,
  output logic switch_output_c,
  input wire logic station_sel_a,
  input wire logic station_sel_b,
  input wire logic station_sel_c,
  input wire logic station_sel_d,
  input wire logic radio_rx_in,
  output logic radio_tx_out,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // sized copies of the bit times and the hold count
  localparam logic [15:0] HOST_BC = 16'(HOST_BIT_CYC);
  localparam logic [15:0] LINK_BC = 16'(LINK_BIT_CYC);
  localparam logic [24:0] HOLD_BC = 25'(HOLD_CYC);

  // idle engine
  localparam rle_uart_t UART_IDLE = '{ph: RLE_IDLE, cnt: 16'h0000,
                                      bits: 4'h0, sh: 9'h000};

  rle_state_t st_reg;  // registered state
  rle_state_t st_next; // next state

  logic [3:0] station;   // own address, a is msb
  logic [7:0] status_b;  // outgoing status byte
  logic any_in;          // any switch input high
  logic host_done;       // host byte complete
  logic rad_done;        // radio frame complete
  logic acc;             // apb access phase
  logic mapped;          // address decodes
  logic [7:0] rb;        // received radio byte
  logic ser_line;        // serial tx line now
  logic rad_line;        // radio tx line now

  // receive one bit-serial frame, mid-bit sampling
  function automatic rle_uart_t rx_step(input rle_uart_t e,
      input logic line, input logic [15:0] bc, input logic [3:0] nb,
      output logic done);
    rle_uart_t n;
    n = e;
    done = 1'b0;
    case (e.ph)
      RLE_IDLE: begin
        if (!line) begin
          n.ph = RLE_START;     // start edge seen
          n.cnt = bc >> 1;
        end
      end
      RLE_START: begin
        if (e.cnt != 16'h0000) begin
          n.cnt = e.cnt - 16'h0001;
        end else if (!line) begin
          n.ph = RLE_DATA;      // start confirmed mid-bit
          n.cnt = bc - 16'h0001;
          n.bits = 4'h0;
        end else begin
          n.ph = RLE_IDLE;      // glitch, drop
        end
      end
      RLE_DATA: begin
        if (e.cnt != 16'h0000) begin
          n.cnt = e.cnt - 16'h0001;
        end else begin
          n.sh[e.bits] = line;  // lsb first
          n.cnt = bc - 16'h0001;
          if (e.bits == nb - 4'h1) begin
            n.ph = RLE_STOP;
          end else begin
            n.bits = e.bits + 4'h1;
          end
        end
      end
      RLE_STOP: begin
        if (e.cnt != 16'h0000) begin
          n.cnt = e.cnt - 16'h0001;
        end else begin
          n.ph = RLE_IDLE;
          done = line;          // good stop bit only
        end
      end
      default: begin
        n = UART_IDLE;
      end
    endcase
    return n;
  endfunction

  // transmit one frame: start, nb data bits lsb first, stop
  function automatic rle_uart_t tx_step(input rle_uart_t e,
      input logic go, input logic [8:0] d, input logic [15:0] bc,
      input logic [3:0] nb, output logic line);
    rle_uart_t n;
    n = e;
    line = 1'b1;
    case (e.ph)
      RLE_IDLE: begin
        if (go) begin
          n.ph = RLE_START;     // load frame
          n.cnt = bc - 16'h0001;
          n.sh = d;
        end
      end
      RLE_START: begin
        line = 1'b0;
        if (e.cnt != 16'h0000) begin
          n.cnt = e.cnt - 16'h0001;
        end else begin
          n.ph = RLE_DATA;
          n.cnt = bc - 16'h0001;
          n.bits = 4'h0;
        end
      end
      RLE_DATA: begin
        line = e.sh[e.bits];
        if (e.cnt != 16'h0000) begin
          n.cnt = e.cnt - 16'h0001;
        end else begin
          n.cnt = bc - 16'h0001;
          if (e.bits == nb - 4'h1) begin
            n.ph = RLE_STOP;
          end else begin
            n.bits = e.bits + 4'h1;
          end
        end
      end
      RLE_STOP: begin
        if (e.cnt != 16'h0000) begin
          n.cnt = e.cnt - 16'h0001;
        end else begin
          n.ph = RLE_IDLE;
        end
      end
      default: begin
        n = UART_IDLE;
      end
    endcase
    return n;
  endfunction

  // pin-level helpers
  always_comb begin
    station = {station_sel_a, station_sel_b,
               station_sel_c, station_sel_d};
    any_in = switch_input_a | switch_input_b | switch_input_c;
    status_b = {~switch_input_a, ~switch_input_b, ~switch_input_c,
                ~station, 1'b0};
    acc = psel & penable;
    mapped = (paddr == `RLE_CTRL_OFS) || (paddr == `RLE_STATUS_OFS) ||
             (paddr == `RLE_LASTRX_OFS) || (paddr == `RLE_RXCNT_OFS);
  end

  // next-state logic for the whole endpoint
  always_comb begin
    st_next = st_reg;
    // mode pin takes effect on the next edge
    st_next.serial_mode = mode_sel;

    // host input engine runs only in serial mode
    if (st_reg.serial_mode) begin
      st_next.host_rx = rx_step(st_reg.host_rx, ser_in, HOST_BC,
                                `RLE_HOST_BITS, host_done);
    end else begin
      st_next.host_rx = UART_IDLE;
      host_done = 1'b0;
    end
    // radio transmit: held byte or repeated status byte
    if (st_reg.serial_mode) begin
      st_next.rad_tx = tx_step(st_reg.rad_tx,
          st_reg.host_full & st_reg.link_en,
          {1'b0, st_reg.host_byte}, LINK_BC,
          `RLE_LINK_BITS, rad_line);
      if (st_reg.rad_tx.ph == RLE_IDLE && st_reg.host_full &&
          st_reg.link_en) begin
        st_next.host_full = 1'b0;                   // byte handed over
      end
    end else begin
      st_next.rad_tx = tx_step(st_reg.rad_tx, any_in & st_reg.link_en,
          {1'b1, status_b}, LINK_BC,
          `RLE_LINK_BITS, rad_line);
      st_next.host_full = 1'b0;
    end
    st_next.rad_out = rad_line;
    // full buffer drops a late byte; one freed this cycle takes it
    if (host_done && !st_next.host_full) begin
      st_next.host_full = 1'b1;
      st_next.host_byte = st_next.host_rx.sh[7:0];
    end

    // pacing: low only when a byte can be taken
    st_next.pace = st_reg.serial_mode ?
        (st_next.host_full | (st_next.host_rx.ph != RLE_IDLE)) :
        1'b1;

    // radio receive
    st_next.rad_rx = rx_step(st_reg.rad_rx, radio_rx_in, LINK_BC,
                             `RLE_LINK_BITS, rad_done);
    rb = st_next.rad_rx.sh[7:0];
    if (rad_done) begin
      st_next.last_rx = st_next.rad_rx.sh;
      st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
    end

    // hold timers run down; expiry drops a timed output
    for (int i = 0; i < 3; i++) begin
      if (st_reg.sw_timed[i] && st_reg.sw_out[i]) begin
        if (st_reg.hold[i] == 25'h000_0000) begin
          st_next.sw_out[i] = 1'b0;
        end else begin
          st_next.hold[i] = st_reg.hold[i] - 25'h000_0001;
        end
      end
    end

    // switch-mode decode; bit 0 never looked at
    if (!st_reg.serial_mode && rad_done &&
        (~rb[`RLE_SB_ST_HI:`RLE_SB_ST_LO] == station)) begin
      for (int i = 0; i < 3; i++) begin
        if (st_next.rad_rx.sh[`RLE_ORIGIN_BIT]) begin
          // switch sender: refresh high outputs, low ones time out
          st_next.sw_timed[i] = 1'b1;
          if (!rb[`RLE_SB_SW_LO + i]) begin
            st_next.sw_out[i] = 1'b1;
            st_next.hold[i] = HOLD_BC;
          end else if (!st_reg.sw_timed[i]) begin
            st_next.hold[i] = HOLD_BC;              // latched level: full hold
          end
        end else begin
          // serial sender: levels latch as sent
          st_next.sw_timed[i] = 1'b0;
          st_next.sw_out[i] = ~rb[`RLE_SB_SW_LO + i];
        end
      end
    end
    if (st_reg.serial_mode) begin
      st_next.sw_out = 3'b000;
      st_next.sw_timed = 3'b000;
    end

    // host output engine, serial mode only
    st_next.host_tx = tx_step(st_reg.host_tx,
        st_reg.serial_mode & rad_done, {1'b0, rb}, HOST_BC,
        `RLE_HOST_BITS, ser_line);
    st_next.ser_out = st_reg.serial_mode ? ser_line : 1'b1;

    // apb: read data captured in setup phase
    if (psel && !penable) begin
      case (paddr)
        `RLE_CTRL_OFS: begin
          st_next.prdata = {31'h0000_0000, st_reg.link_en};
        end
        `RLE_STATUS_OFS: begin
          st_next.prdata = {22'h00_0000,
              st_reg.rad_tx.ph != RLE_IDLE, station,
              st_reg.sw_out, st_reg.pace, st_reg.serial_mode};
        end
        `RLE_LASTRX_OFS: begin
          st_next.prdata = {23'h00_0000, st_reg.last_rx};
        end
        `RLE_RXCNT_OFS: begin
          st_next.prdata = {16'h0000, st_reg.rx_cnt};
        end
        default: begin
          st_next.prdata = 32'h0000_0000;           // unmapped
        end
      endcase
    end
    // apb write takes effect in the access cycle
    if (acc && pwrite && paddr == `RLE_CTRL_OFS) begin
      st_next.link_en = pwdata[`RLE_CTRL_LINK_EN];
    end
  end

  // state register, synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '{serial_mode: 1'b0,
                  link_en: 1'(`RLE_CTRL_RST >> `RLE_CTRL_LINK_EN),
                  host_rx: UART_IDLE, host_tx: UART_IDLE,
                  rad_rx: UART_IDLE, rad_tx: UART_IDLE,
                  host_full: 1'b0, host_byte: 8'h00,
                  ser_out: 1'b1, rad_out: 1'b1, pace: 1'b1,
                  sw_out: 3'b000, sw_timed: 3'b000,
                  hold: '0, last_rx: 9'h000, rx_cnt: 16'h0000,
                  prdata: 32'h0000_0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  always_comb begin
    pace_busy_out = st_reg.pace;
    ser_out = st_reg.ser_out;
    radio_tx_out = st_reg.rad_out;
    switch_output_a = st_reg.sw_out[2];
    switch_output_b = st_reg.sw_out[1];
    switch_output_c = st_reg.sw_out[0];
    prdata = st_reg.prdata;
    pready = 1'b1;                                  // zero wait states
    pslverr = acc & ~mapped;
  end

endmodule

// *** rle_map.svh ***
// rle_map.svh: register offsets, field positions, reset values and timing
// counts of the remote link endpoint; assumes a 40 MHz system clock.
`ifndef RLE_MAP_SVH
`define RLE_MAP_SVH

// system clock rate in hertz
`define RLE_CLK_HZ 40000000

// host-facing serial rate and radio link rate, in baud
`define RLE_HOST_BAUD 9600
`define RLE_LINK_BAUD 1200
// cycles per bit, rounded to nearest
`define RLE_HOST_BIT_CYC ((`RLE_CLK_HZ + `RLE_HOST_BAUD / 2) / `RLE_HOST_BAUD)
`define RLE_LINK_BIT_CYC ((`RLE_CLK_HZ + `RLE_LINK_BAUD / 2) / `RLE_LINK_BAUD)

// switch output hold after the far input drops, in milliseconds
`define RLE_HOLD_MS 500
`define RLE_HOLD_CYC ((`RLE_CLK_HZ / 1000) * `RLE_HOLD_MS)

// frame sizes in data bits
`define RLE_HOST_BITS 4'h8
`define RLE_LINK_BITS 4'h9

// apb byte offsets
`define RLE_CTRL_OFS 8'h00
`define RLE_STATUS_OFS 8'h04
`define RLE_LASTRX_OFS 8'h08
`define RLE_RXCNT_OFS 8'h0C

// control fields and reset value
`define RLE_CTRL_LINK_EN 0
`define RLE_CTRL_RST 32'h0000_0001

// status fields
`define RLE_ST_SERIAL 0
`define RLE_ST_PACE 1
`define RLE_ST_SWOUT_LO 2
`define RLE_ST_STATION_LO 5
`define RLE_ST_TXBUSY 9

// status byte fields
`define RLE_SB_SW_HI 7
`define RLE_SB_SW_LO 5
`define RLE_SB_ST_HI 4
`define RLE_SB_ST_LO 1
// radio frame bit marking a switch-mode sender
`define RLE_ORIGIN_BIT 8

`endif

// *** rle_pkg.sv ***
// rle_pkg.sv: types of the remote link endpoint.
// assumes rle_map.svh is on the include path.
package rle_pkg;

  // serial engine phase, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    RLE_IDLE  = 2'b00,
    RLE_START = 2'b01,
    RLE_DATA  = 2'b11,
    RLE_STOP  = 2'b10
  } rle_phase_t;

  // one serial engine, receive or transmit
  typedef struct packed {
    rle_phase_t ph;     // frame phase
    logic [15:0] cnt;   // cycles left in bit
    logic [3:0] bits;   // data bit index
    logic [8:0] sh;     // frame data
  } rle_uart_t;

  // whole state of the endpoint
  typedef struct packed {
    logic serial_mode;        // registered mode pin
    logic link_en;            // control: radio transmit allowed
    rle_uart_t host_rx;       // 9600 input engine
    rle_uart_t host_tx;       // 9600 output engine
    rle_uart_t rad_rx;        // 1200 radio receive
    rle_uart_t rad_tx;        // 1200 radio transmit
    logic host_full;          // held input byte waiting
    logic [7:0] host_byte;    // held input byte
    logic ser_out;            // serial output line
    logic rad_out;            // radio output line
    logic pace;               // pacing output
    logic [2:0] sw_out;       // switch outputs, [2]=a
    logic [2:0] sw_timed;     // output drops on hold expiry
    logic [2:0][24:0] hold;   // hold timers
    logic [8:0] last_rx;      // last radio frame
    logic [15:0] rx_cnt;      // radio frames taken
    logic [31:0] prdata;      // apb read data
  } rle_state_t;

endpackage

// *** rle_endpoint_properties.sv ***
// checker of the endpoint's port behaviour
// assumes binding into rle_endpoint, one clock domain
`timescale 1ns/1ps
module rle_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode_sel,
  input wire logic pace_busy_out,
  input wire logic ser_out,
  input wire logic switch_input_a,
  input wire logic switch_input_b,
  input wire logic switch_input_c,
  input wire logic switch_output_a,
  input wire logic switch_output_b,
  input wire logic switch_output_c,
  input wire logic radio_rx_in,
  input wire logic radio_tx_out,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // access phase and decoded word address
  wire logic acc = psel && penable;
  wire logic mapped = (paddr[1:0] == 2'b00) && (paddr < 8'h10);
  wire logic any_in = switch_input_a | switch_input_b | switch_input_c;
  wire logic any_out = switch_output_a | switch_output_b | switch_output_c;
  // reset drives every line to its idle level
  property p_reset;
    disable iff (1'b0) rst |=> pace_busy_out && ser_out && radio_tx_out
      && !any_out && prdata == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset) else $error("reset levels wrong");
  property p_pace_sw;
    !mode_sel [*3] |-> pace_busy_out;
  endproperty
  a_pace_sw: assert property (p_pace_sw) else $error("pace low in switch");
  property p_rxd_sw;
    !mode_sel [*3] |-> ser_out;
  endproperty
  a_rxd_sw: assert property (p_rxd_sw) else $error("serial out active");
  property p_out_ser;
    mode_sel [*3] |-> !any_out;
  endproperty
  a_out_ser: assert property (p_out_ser) else $error("switch out in serial");
  property p_err;
    acc && !mapped |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok;
    !(acc && !mapped) |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("spurious slave error");
  property p_rdy;
    acc |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered");
  // a switch sender stays silent while all inputs are low
  property p_quiet;
    (!mode_sel && !any_in) [*8] |-> !$fell(radio_tx_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("frame with inputs low");
  // switch output a rises only at the stop bit of a received frame
  property p_rise;
    !mode_sel [*4] ##0 $rose(switch_output_a) |-> $past(radio_rx_in);
  endproperty
  a_rise: assert property (p_rise) else $error("output rose off frame");
  c_err: cover property (acc && pslverr);
  c_rise: cover property ($rose(switch_output_a));
  c_frame: cover property (!mode_sel && $fell(radio_tx_out));
endmodule
bind rle_endpoint rle_chk rle_chk_i (.mclk, .rst, .mode_sel, .pace_busy_out,
  .ser_out, .switch_input_a, .switch_input_b, .switch_input_c,
  .switch_output_a, .switch_output_b, .switch_output_c, .radio_rx_in,
  .radio_tx_out, .psel, .penable, .paddr, .prdata, .pready, .pslverr);

// *** rle_far.sv ***
// far side: host serial sender and radio peer, plus line sampler
// assumes callers start tasks just after a rising mclk edge
`timescale 1ns/1ps
module rle_far (
  input wire logic mclk,
  output logic host_line,
  output logic radio_line,
  input wire logic dev_ser,
  input wire logic dev_radio
);
  // both lines idle high between frames
  initial begin
    host_line = 1'b1;
    radio_line = 1'b1;
  end
  // start, lsb-first data, stop; caller spaces frames
  task automatic send(input bit rad, input logic [8:0] d, input int nb,
    input int bc);
    logic v;
    for (int i = -1; i <= nb; i++) begin
      v = (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : d[i];
      if (rad) radio_line <= v;
      else host_line <= v;
      repeat (bc) @(posedge mclk);
    end
  endtask
  // samples nb data bits and the stop bit at bit centres
  task automatic grab(input bit rad, input int nb, input int bc,
    output logic [9:0] d);
    int t;
    t = 0;
    d = '0;
    while ((rad ? dev_radio : dev_ser) !== 1'b0 && t < 40000) begin
      @(posedge mclk);
      t++;
    end
    repeat (bc / 2) @(posedge mclk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bc) @(posedge mclk);
      d[i] = rad ? dev_radio : dev_ser;
    end
  endtask
endmodule

// *** tb.sv ***
// self-checking bench of the remote link endpoint
// assumes reduced bit and hold counts set below
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("FAIL %s exp %h got %h", w, e, g); end end
module tb;
  localparam int HB = 16;
  localparam int LB = 400;
  localparam int HC = 2000;
  logic mclk, rst, mode_sel, psel, penable, pwrite;
  logic [2:0] sw_in;
  logic [3:0] st;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  wire ser_in, radio_rx_in, pace_busy_out, ser_out, radio_tx_out;
  wire pready, pslverr;
  wire [2:0] sw_out;
  wire [31:0] prdata;
  int n_mismatch, checks_done;
  rle_endpoint #(.HOST_BIT_CYC(HB), .LINK_BIT_CYC(LB), .HOLD_CYC(HC))
    rle_endpoint_i (.mclk, .rst, .mode_sel, .ser_in, .pace_busy_out,
    .ser_out, .switch_input_a(sw_in[2]), .switch_input_b(sw_in[1]),
    .switch_input_c(sw_in[0]), .switch_output_a(sw_out[2]),
    .switch_output_b(sw_out[1]), .switch_output_c(sw_out[0]),
    .station_sel_a(st[3]), .station_sel_b(st[2]), .station_sel_c(st[1]),
    .station_sel_d(st[0]), .radio_rx_in, .radio_tx_out, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  rle_far far_i (.mclk, .host_line(ser_in), .radio_line(radio_rx_in),
    .dev_ser(ser_out), .dev_radio(radio_tx_out));
  // one apb transfer, held until pready
  task automatic apb(input bit wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && t < 100) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 100) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // radio frame to the switch receiver, then output check
  task automatic rx_sw(input logic [8:0] fr, input logic [2:0] e);
    far_i.send(1'b1, fr, 9, LB);
    repeat (4) @(posedge mclk);
    `CHK("sw_out", e, sw_out)
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    int t;
    logic [9:0] f;
    logic [31:0] rd;
    logic er;
    rst = 1'b1;
    mode_sel = 1'b1;
    sw_in = 3'h0;
    st = 4'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(posedge mclk);
    `CHK("rst pace", 1'b1, pace_busy_out)
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("pace idle", 1'b0, pace_busy_out)
    apb(1'b0, 8'h00, 32'h0000_0000, rd, er);
    `CHK("ctrl", 32'h0000_0001, rd)
    apb(1'b0, 8'h04, 32'h0000_0000, rd, er);
    `CHK("serial mode", 1'b1, rd[0])
    apb(1'b0, 8'h10, 32'h0000_0000, rd, er);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, 8'h00, 32'h0000_0000, rd, er);
    apb(1'b0, 8'h00, 32'h0000_0000, rd, er);
    `CHK("ctrl wr", 32'h0000_0000, rd)
    apb(1'b1, 8'h00, 32'h0000_0001, rd, er);
    // host bytes forwarded as serial-origin radio frames
    for (int k = 0; k < 2; k++) begin
      fork
        far_i.send(1'b0, k ? 9'h05A : 9'h0A5, 8, HB);
        far_i.grab(1'b1, 9, LB, f);
        begin
          repeat (3 * HB) @(posedge mclk);
          `CHK("pace busy", 1'b1, pace_busy_out)
        end
      join
      `CHK("radio frame", k ? 10'h25A : 10'h2A5, f)
      t = 0;
      while (pace_busy_out !== 1'b0 && t < 20000) begin
        @(posedge mclk);
        t++;
      end
      `CHK("pace free", 1'b0, pace_busy_out)
    end
    fork
      far_i.send(1'b1, 9'h03C, 9, LB);
      far_i.grab(1'b0, 8, HB, f);
    join
    `CHK("serial out", 10'h13C, f)
    // switch mode, station a, then b, then zero
    mode_sel <= 1'b0;
    st <= 4'b1000;
    repeat (4) @(posedge mclk);
    `CHK("pace sw", 1'b1, pace_busy_out)
    apb(1'b0, 8'h04, 32'h0000_0000, rd, er);
    `CHK("switch mode", 5'b10000, {rd[8:5], rd[0]})
    repeat (600) @(posedge mclk);
    `CHK("radio quiet", 1'b1, radio_tx_out)
    sw_in <= 3'b100;
    repeat (2) begin
      far_i.grab(1'b1, 9, LB, f);
      `CHK("status frame", 10'h36E, f)
    end
    sw_in <= 3'b000;
    st <= 4'b0100;
    rx_sw(9'h0B6, 3'b010);
    rx_sw(9'h01F, 3'b010);
    rx_sw(9'h017, 3'b111);
    st <= 4'b0000;
    rx_sw(9'h05E, 3'b101);
    rx_sw(9'h17E, 3'b101);
    repeat (HC / 2) @(posedge mclk);
    `CHK("held", 3'b101, sw_out)
    repeat (HC) @(posedge mclk);
    `CHK("dropped", 3'b000, sw_out)
    mode_sel <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("ser idle", 1'b1, ser_out)
    complete_run;
  end
endmodule
